/* inc/csc_pkg.sv */
// ****************************************************************
// constants of the clock synthesizer serial control
// ****************************************************************
package csc_pkg;

  // system clock rate and fastest serial clock
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned SCL_MAX_KHZ  = 400;
  // system cycles in the shortest serial clock half period
  localparam int unsigned SCL_HALF_CYC = (CLK_FREQ_MHZ * 1000) / (2 * SCL_MAX_KHZ);

  // own seven bit slave address, 8'hd2 with the direction bit
  localparam logic [6:0] SLAVE_ADDR  = 7'h69;
  // byte count returned first in a block read
  localparam logic [7:0] BLOCK_COUNT = 8'h05;
  localparam logic [4:0] NUM_BYTES   = 5'h05;
  localparam logic [3:0] BITS_FULL   = 4'h8;

  // byte offsets
  localparam logic [4:0] OFS_GATE   = 5'h00;
  localparam logic [4:0] OFS_SPREAD = 5'h02;

  // command code fields
  localparam int unsigned CMD_SINGLE_BIT = 7;
  localparam int unsigned CMD_CS_HI      = 6;
  localparam int unsigned CMD_CS_LO      = 5;
  localparam int unsigned CMD_IDX_HI     = 4;
  localparam logic [1:0]  CMD_CS_OWN     = 2'h0;

  // control bit positions
  localparam int unsigned BIT_GATE1     = 3;
  localparam int unsigned BIT_GATE2     = 4;
  localparam int unsigned BIT_GATE3     = 5;
  localparam int unsigned BIT_GATE4     = 6;
  localparam int unsigned BIT_SPREAD_EN = 2;
  localparam int unsigned BIT_DEPTH     = 7;

  // power-up values, byte 4 leftmost
  localparam logic [4:0][7:0] RESET_VALUES = {8'h01, 8'haf, 8'hea, 8'h00, 8'h7c};
  // writable bits, all others keep their power-up value
  localparam logic [4:0][7:0] WRITE_MASKS  = {8'h00, 8'h00, 8'h84, 8'h00, 8'h78};

  // pin levels assumed before the first sample
  localparam logic [2:0] SYNC_IDLE = 3'h3;
  localparam logic [1:0] PREV_IDLE = 2'h3;

  // byte engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_RACK = 5'h10
  } csc_state_t;

  // meaning of the next byte on the wire
  typedef enum logic [3:0] {
    RL_ADDR  = 4'h1,
    RL_CMD   = 4'h2,
    RL_COUNT = 4'h4,
    RL_DATA  = 4'h8
  } csc_role_t;

endpackage

/* core/csc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pin synchroniser and bus event detector
// ****************************************************************
module csc_pin_sync (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  input  wire logic scl_pin_in,
  input  wire logic sda_pin_in,
  input  wire logic ref_pin_in,
  output wire logic scl_rise_out,
  output wire logic scl_fall_out,
  output wire logic start_out,
  output wire logic stop_out,
  output wire logic sda_level_out,
  output wire logic ref_level_out
);
  import csc_pkg::*;

  // bit order in the stages is {ref, sda, scl}
  typedef struct packed {
    logic [2:0] meta;   // first stage, read by sync only
    logic [2:0] sync;   // second stage
    logic [1:0] prev;   // delayed sda, scl for edges
    logic       rise;   // scl rising
    logic       fall;   // scl falling
    logic       start;  // sda falls, scl high
    logic       stop;   // sda rises, scl high
    logic       sda;    // sda aligned with pulses
    logic       ref_l;  // reference select level
  } csc_sync_t;

  localparam csc_sync_t SYNC_RST = '{meta: SYNC_IDLE, sync: SYNC_IDLE, prev: PREV_IDLE,
                                     sda: 1'b1, default: '0};

  csc_sync_t q;  // registered state
  csc_sync_t d;  // next state

  // ****************************************************************
  // next state
  // ****************************************************************
  // edges taken from second stage against its delayed copy
  always_comb begin
    d       = q;
    d.meta  = {ref_pin_in, sda_pin_in, scl_pin_in};
    d.sync  = q.meta;
    d.prev  = q.sync[1:0];
    d.rise  = q.sync[0] & ~q.prev[0];
    d.fall  = ~q.sync[0] & q.prev[0];
    d.start = q.sync[0] & q.prev[0] & ~q.sync[1] & q.prev[1];
    d.stop  = q.sync[0] & q.prev[0] & q.sync[1] & ~q.prev[1];
    d.sda   = q.sync[1];
    d.ref_l = q.sync[2];
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      q <= SYNC_RST;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  assign scl_rise_out  = q.rise;
  assign scl_fall_out  = q.fall;
  assign start_out     = q.start;
  assign stop_out      = q.stop;
  assign sda_level_out = q.sda;
  assign ref_level_out = q.ref_l;

endmodule
`default_nettype wire

/* core/csc_serial_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - all bytes take fixed defaults at reset
// - byte and block reads and writes supported
// - block bytes ascend from lowest, msb first
// - block may end after any whole byte
// - answer only slave address 8'hd2
// - command bit 7 picks single or block
// - command bits 4:0 index single byte
// - block write: address, command, count, data
// - block read: count then data, last nacked
// - single write: address, command, one byte
// - single read: one byte then nack, stop
// - byte 0 bits 6:3 gate four outputs
// - byte 2 bit 7 picks spread depth
// - byte 2 bit 2 turns spread on
// - reference select pin picks pll reference
// - serial link works up to 400 khz
module csc_serial_ctrl (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_data_pin_in,
  input  wire logic ref_select_in,
  output wire logic serial_data_pin_out,
  output wire logic serial_data_pin_oe_n_out,
  output wire logic first_output_gate_out,
  output wire logic second_output_gate_out,
  output wire logic third_output_gate_out,
  output wire logic fourth_output_gate_out,
  output wire logic spread_enable_out,
  output wire logic spread_depth_sel_out,
  output wire logic ref_select_out
);
  import csc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    csc_state_t      state;     // byte engine
    csc_role_t       role;      // meaning of current byte
    logic [3:0]      bitcnt;    // bits moved in byte
    logic [7:0]      shreg;     // shift register
    logic            rw;        // read direction
    logic            single;    // single byte access
    logic            mack;      // controller acknowledged
    logic [4:0]      idx;       // byte index
    logic [4:0][7:0] regs;      // configuration bytes
    logic            sda_oe_n;  // low drives the data pin
    logic            drv_lvl;   // level when driving
    logic            ref_sel;   // reference select
  } csc_core_t;

  localparam csc_core_t CORE_RST = '{state: ST_IDLE, role: RL_ADDR, regs: RESET_VALUES,
                                     sda_oe_n: 1'b1, default: '0};

  csc_core_t q;          // registered state
  csc_core_t d;          // next state
  logic      scl_rise;   // serial clock rising
  logic      scl_fall;   // serial clock falling
  logic      bus_start;  // start or repeated start
  logic      bus_stop;   // stop
  logic      sda_lvl;    // sampled data pin
  logic      ref_lvl;    // sampled reference select

  // ****************************************************************
  // helpers
  // ****************************************************************
  // byte for readback, zero past the last byte
  function automatic logic [7:0] rd_byte(input logic [4:0][7:0] regs, input logic [4:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx < NUM_BYTES) begin
      v = regs[idx[2:0]];
    end
    return v;
  endfunction

  // write only the writable bits of a byte
  function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] din,
                                          input logic [7:0] mask);
    return (old & ~mask) | (din & mask);
  endfunction

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  csc_pin_sync u_sync (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .clk_en_in     (clk_en_in),
    .scl_pin_in    (serial_clock_in),
    .sda_pin_in    (serial_data_pin_in),
    .ref_pin_in    (ref_select_in),
    .scl_rise_out  (scl_rise),
    .scl_fall_out  (scl_fall),
    .start_out     (bus_start),
    .stop_out      (bus_stop),
    .sda_level_out (sda_lvl),
    .ref_level_out (ref_lvl)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  // sampling at 200 mhz leaves SCL_HALF_CYC cycles per half bit at 400 khz
  always_comb begin
    logic [7:0] nb;  // next byte to send
    nb        = 8'h00;
    d         = q;
    d.ref_sel = ref_lvl;
    d.drv_lvl = 1'b0;
    if (bus_start) begin
      // start or repeated start, keeps mode and index
      d.state    = ST_RX;
      d.role     = RL_ADDR;
      d.bitcnt   = 4'h0;
      d.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      // stop ends any transfer, written bytes stay
      d.state    = ST_IDLE;
      d.sda_oe_n = 1'b1;
    end else begin
      unique case (q.state)
        ST_IDLE: begin
          // wait for a start
          d.sda_oe_n = 1'b1;
        end
        ST_RX: begin
          if (scl_rise) begin
            // msb arrives first
            d.shreg  = {q.shreg[6:0], sda_lvl};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == BITS_FULL) begin
            // whole byte in, acknowledge by default
            d.state    = ST_ACK;
            d.sda_oe_n = 1'b0;
            d.bitcnt   = 4'h0;
            unique case (q.role)
              RL_ADDR: begin
                if (q.shreg[7:1] != SLAVE_ADDR) begin
                  // not ours, leave the bus alone
                  d.state    = ST_IDLE;
                  d.sda_oe_n = 1'b1;
                end else begin
                  d.rw   = q.shreg[0];
                  d.role = RL_CMD;
                  if (q.shreg[0]) begin
                    // read: byte count first or the indexed byte
                    d.role  = RL_DATA;
                    d.shreg = q.single ? rd_byte(q.regs, q.idx) : BLOCK_COUNT;
                  end
                end
              end
              RL_CMD: begin
                if (q.shreg[CMD_CS_HI:CMD_CS_LO] != CMD_CS_OWN) begin
                  // other chip select, no acknowledge
                  d.state    = ST_IDLE;
                  d.sda_oe_n = 1'b1;
                end else begin
                  // mode and index from the command
                  d.single = q.shreg[CMD_SINGLE_BIT];
                  d.idx    = q.shreg[CMD_SINGLE_BIT] ? q.shreg[CMD_IDX_HI:0] : 5'h00;
                  d.role   = q.shreg[CMD_SINGLE_BIT] ? RL_DATA : RL_COUNT;
                end
              end
              RL_COUNT: begin
                // count is acknowledged, data follows
                d.role = RL_DATA;
              end
              RL_DATA: begin
                // store writable bits only
                if (q.idx < NUM_BYTES) begin
                  d.regs[q.idx[2:0]] = wr_merge(q.regs[q.idx[2:0]], q.shreg, WRITE_MASKS[q.idx[2:0]]);
                end
                // block write walks upward
                if (!q.single && q.idx < NUM_BYTES) begin
                  d.idx = q.idx + 5'h01;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              // first bit of read byte right after the ack
              d.state    = ST_TX;
              d.sda_oe_n = q.shreg[7];
              d.shreg    = {q.shreg[6:0], 1'b0};
              d.bitcnt   = 4'h1;
            end else begin
              d.state    = ST_RX;
              d.sda_oe_n = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == BITS_FULL) begin
              // release for the controller ack
              d.state    = ST_RACK;
              d.sda_oe_n = 1'b1;
            end else begin
              // next bit, msb first
              d.sda_oe_n = q.shreg[7];
              d.shreg    = {q.shreg[6:0], 1'b0};
              d.bitcnt   = q.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            d.mack = ~sda_lvl;
          end else if (scl_fall) begin
            if (q.mack) begin
              // acked: next byte, ascending in block mode, same byte again in single mode
              nb         = rd_byte(q.regs, q.idx);
              d.state    = ST_TX;
              d.sda_oe_n = nb[7];
              d.shreg    = {nb[6:0], 1'b0};
              d.bitcnt   = 4'h1;
              if (!q.single && q.idx < NUM_BYTES) begin
                d.idx = q.idx + 5'h01;
              end
            end else begin
              // nack ends the read, wait for stop
              d.state    = ST_IDLE;
              d.sda_oe_n = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset loads every byte default
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      q <= CORE_RST;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign serial_data_pin_out      = q.drv_lvl;
  assign serial_data_pin_oe_n_out = q.sda_oe_n;
  assign first_output_gate_out    = q.regs[OFS_GATE[2:0]][BIT_GATE1];
  assign second_output_gate_out   = q.regs[OFS_GATE[2:0]][BIT_GATE2];
  assign third_output_gate_out    = q.regs[OFS_GATE[2:0]][BIT_GATE3];
  assign fourth_output_gate_out   = q.regs[OFS_GATE[2:0]][BIT_GATE4];
  assign spread_enable_out        = q.regs[OFS_SPREAD[2:0]][BIT_SPREAD_EN];
  assign spread_depth_sel_out     = q.regs[OFS_SPREAD[2:0]][BIT_DEPTH];
  assign ref_select_out           = q.ref_sel;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_reset_defaults: assert property (@(posedge clock_in)
    reset_in |=> (q.regs == RESET_VALUES) && spread_enable_out == 1'b0 && spread_depth_sel_out)
    else $error("bytes not at defaults after reset");

  chk_reserved_kept: assert property (@(posedge clock_in) disable iff (reset_in)
    ((q.regs & ~WRITE_MASKS) == (RESET_VALUES & ~WRITE_MASKS)))
    else $error("reserved bits changed");

  chk_foreign_addr: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !bus_start && !bus_stop && q.state == ST_RX && q.role == RL_ADDR && scl_fall
     && q.bitcnt == BITS_FULL && q.shreg[7:1] != SLAVE_ADDR) |=> (q.state == ST_IDLE && q.sda_oe_n))
    else $error("foreign address acknowledged");

  chk_start_restart: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && bus_start) |=> (q.state == ST_RX && q.role == RL_ADDR && q.bitcnt == 4'h0))
    else $error("start not taken");

  chk_stop_release: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && bus_stop && !bus_start) |=> (q.state == ST_IDLE && q.sda_oe_n && $stable(q.regs)))
    else $error("stop did not release bus");

  chk_msb_first: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !bus_start && !bus_stop && q.state == ST_TX && scl_fall && q.bitcnt != BITS_FULL)
    |=> (q.sda_oe_n == $past(q.shreg[7])))
    else $error("read bit out of order");

  chk_cmd_mode: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !bus_start && !bus_stop && q.state == ST_RX && q.role == RL_CMD && scl_fall
     && q.bitcnt == BITS_FULL && q.shreg[CMD_CS_HI:CMD_CS_LO] == CMD_CS_OWN)
    |=> (q.single == $past(q.shreg[CMD_SINGLE_BIT])
         && q.idx == ($past(q.shreg[CMD_SINGLE_BIT]) ? $past(q.shreg[CMD_IDX_HI:0]) : 5'h00)))
    else $error("command decode wrong");

  chk_data_write: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !bus_start && !bus_stop && q.state == ST_RX && q.role == RL_DATA && scl_fall
     && q.bitcnt == BITS_FULL && q.idx == OFS_SPREAD)
    |=> (q.regs[OFS_SPREAD[2:0]] == wr_merge($past(q.regs[OFS_SPREAD[2:0]]), $past(q.shreg),
                                             WRITE_MASKS[OFS_SPREAD[2:0]])))
    else $error("written byte not stored");

  chk_nack_ends: assert property (@(posedge clock_in) disable iff (reset_in)
    (clk_en_in && !bus_start && !bus_stop && q.state == ST_RACK && scl_fall && !q.mack)
    |=> (q.state == ST_IDLE && q.sda_oe_n) [*2])
    else $error("read continued after nack");

endmodule
`default_nettype wire

/* bench/csc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-wire bus controller model
// ****************************************************************
module csc_host_model (
  input  wire logic clock_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_pull_n_out
);
  // idle bus, both lines released
  initial begin
    scl_out        = 1'b1;
    sda_pull_n_out = 1'b1;
  end
  // wait whole system cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // 13 cycles low, data set mid-low, ends 6 cycles into high
  task automatic phase(input logic lvl);
    scl_out <= 1'b0;
    tick(6);
    sda_pull_n_out <= lvl;
    tick(7);
    scl_out <= 1'b1;
    tick(6);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_c();
    phase(1'b1);
    sda_pull_n_out <= 1'b0;
    tick(6);
  endtask
  // stop: data rises while clock high
  task automatic stop_c();
    phase(1'b0);
    sda_pull_n_out <= 1'b1;
    tick(6);
  endtask
  // byte out msb first, then sample the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      phase(b[i]);
      tick(6);
    end
    phase(1'b1);
    ack = ~sda_in;
    tick(6);
  endtask
  // byte in msb first, nack on the last one
  task automatic recv(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      phase(1'b1);
      b[i] = sda_in;
      tick(6);
    end
    phase(last);
    tick(6);
  endtask
endmodule
`default_nettype wire

/* bench/tb_clock_synth_serial_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check_val(8'(got), 8'(exp));
// ****************************************************************
// bench of the serial control block
// ****************************************************************
module tb_clock_synth_serial_control;
  import csc_pkg::*;
  localparam int LIMIT = 50000; // cycle ceiling for a hung run
  logic clock_in;               // 200 mhz system clock
  logic reset_in;               // synchronous reset
  logic clk_en_in;              // clock enable, high except for a pause in the defaults test
  logic ref_sel;                // reference select pin
  logic scl;                    // serial clock from controller
  logic host_pull_n;            // controller pulls data low
  logic sda_out;                // device data level
  logic oe_n;                   // device pulls data low
  logic g1, g2, g3, g4;         // output gates
  logic spr_en;                 // spread on
  logic depth;                  // spread depth
  logic ref_out;                // reference choice
  wire  sda_wire;               // resolved data line, pulled up
  int   bad_count;              // mismatches
  int   checked;                // comparisons
  int   cycles;                 // run length
  // ****************************************************************
  // clock, wiring, instances
  // ****************************************************************
  initial clock_in = 1'b0;
  always #2.5 clock_in = ~clock_in;
  assign sda_wire = host_pull_n & (oe_n | sda_out);
  csc_serial_ctrl i_dut (
    .clock_in                 (clock_in),
    .reset_in                 (reset_in),
    .clk_en_in                (clk_en_in),
    .serial_clock_in          (scl),
    .serial_data_pin_in       (sda_wire),
    .ref_select_in            (ref_sel),
    .serial_data_pin_out      (sda_out),
    .serial_data_pin_oe_n_out (oe_n),
    .first_output_gate_out    (g1),
    .second_output_gate_out   (g2),
    .third_output_gate_out    (g3),
    .fourth_output_gate_out   (g4),
    .spread_enable_out        (spr_en),
    .spread_depth_sel_out     (depth),
    .ref_select_out           (ref_out)
  );
  csc_host_model u_host (
    .clock_in       (clock_in),
    .sda_in         (sda_wire),
    .scl_out        (scl),
    .sda_pull_n_out (host_pull_n)
  );
  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end
  // ****************************************************************
  // transfers
  // ****************************************************************
  // start, own address, command
  task automatic frame(input logic [7:0] cmd);
    logic ack;
    u_host.start_c();
    u_host.send(8'hd2, ack);
    `CHK(ack, 1'b1)
    u_host.send(cmd, ack);
    `CHK(ack, 1'b1)
  endtask
  task automatic wr_single(input logic [4:0] idx, input logic [7:0] val);
    logic ack;
    frame({3'h4, idx});
    u_host.send(val, ack);
    `CHK(ack, 1'b1)
    u_host.stop_c();
  endtask
  task automatic rd_single(input logic [4:0] idx, input logic [7:0] exp);
    logic       ack;
    logic [7:0] got;
    frame({3'h4, idx});
    u_host.start_c();
    u_host.send(8'hd3, ack);
    `CHK(ack, 1'b1)
    u_host.recv(1'b1, got);
    `CHK(got, exp)
    u_host.stop_c();
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults();
    `CHK({g4, g3, g2, g1}, 4'hf)
    `CHK(spr_en, 1'b0)
    `CHK(depth, 1'b1)
    `CHK(ref_out, 1'b0)
    ref_sel <= 1'b1;
    repeat (6) @(posedge clock_in);
    `CHK(ref_out, 1'b1)
    // pin change must not pass while the clock enable is low
    clk_en_in <= 1'b0;
    ref_sel   <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK(ref_out, 1'b1)
    clk_en_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    `CHK(ref_out, 1'b0)
    $display("test defaults done");
  endtask
  task automatic t_block_read();
    logic       ack;
    logic [7:0] got;
    logic [7:0] exp [6] = '{8'h05, 8'h7c, 8'h00, 8'hea, 8'haf, 8'h01};
    frame(8'h00);
    u_host.start_c();
    u_host.send(8'hd3, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 6; i++) begin
      u_host.recv(i == 5, got);
      `CHK(got, exp[i])
    end
    u_host.stop_c();
    $display("test block read done");
  endtask
  task automatic t_single();
    wr_single(5'h02, 8'h00);
    `CHK(depth, 1'b0)
    wr_single(5'h02, 8'hff);
    `CHK({depth, spr_en}, 2'h3)
    rd_single(5'h02, 8'hee);
    wr_single(5'h00, 8'h00);
    `CHK({g4, g3, g2, g1}, 4'h0)
    rd_single(5'h00, 8'h04);
    wr_single(5'h07, 8'hff);
    rd_single(5'h07, 8'h00);
    $display("test single done");
  endtask
  task automatic t_block_write_stop();
    logic ack;
    frame(8'h00);
    u_host.send(8'h05, ack);
    `CHK(ack, 1'b1)
    u_host.send(8'h50, ack);
    `CHK(ack, 1'b1)
    u_host.stop_c();
    `CHK({g4, g3, g2, g1}, 4'ha)
    `CHK({depth, spr_en}, 2'h3)
    rd_single(5'h00, 8'h54);
    $display("test block write stop done");
  endtask
  task automatic t_refused();
    logic ack;
    u_host.start_c();
    u_host.send(8'ha0, ack);
    `CHK(ack, 1'b0)
    u_host.send(8'h82, ack);
    `CHK(ack, 1'b0)
    u_host.stop_c();
    u_host.start_c();
    u_host.send(8'hd2, ack);
    u_host.send(8'ha2, ack);
    `CHK(ack, 1'b0)
    u_host.stop_c();
    rd_single(5'h02, 8'hee);
    $display("test refused done");
  endtask
  task automatic t_second_reset();
    reset_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    `CHK({g4, g3, g2, g1}, 4'hf)
    `CHK({depth, spr_en}, 2'h2)
    rd_single(5'h02, 8'hea);
    $display("test second reset done");
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_in  <= 1'b1;
    clk_en_in <= 1'b1;
    ref_sel   <= 1'b0;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    t_defaults();
    t_block_read();
    t_single();
    t_block_write_stop();
    t_refused();
    t_second_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
